// ==== rtl/bmb_pkg.sv ====
// Purpose: Shared constants and types for the basic bus master transfer pair
// Assumes: One global clock, 32-bit data, 4 byte lanes, byte addresses
// Notes: Strobes and byte-lane enables on the bus are active low

package bmb_pkg;

  // Bus widths
  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  localparam int LANE_W = 4;
  localparam int CNT_W = 16;

  // Byte-lane enable patterns, active low, one bit per lane
  localparam logic [LANE_W-1:0] LANES_ALL_N = 4'h0;
  localparam logic [LANE_W-1:0] LANES_NONE_N = 4'hf;
  localparam logic [LANE_W-1:0] LANES_LOW2_N = 4'hc;
  localparam logic [LANE_W-1:0] LANES_HIGH2_N = 4'h3;
  localparam logic [LANE_W-1:0] LANE0_ONLY_N = 4'he;
  localparam logic [LANE_W-1:0] LANE2_ONLY_N = 4'hb;

  // Reset values of the bus side
  localparam logic [ADDR_W-1:0] ADDR_RST = 32'h0000_0000;
  localparam logic [DATA_W-1:0] DATA_RST = 32'h0000_0000;
  localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
  localparam logic STROBE_IDLE_N = 1'b1;

  // Master transfer states, one-hot
  typedef enum logic [2:0] {
    BMB_IDLE = 3'b001,
    BMB_READ = 3'b010,
    BMB_WRITE = 3'b100
  } bmb_state_t;

endpackage : bmb_pkg

// ==== rtl/bmb_if.sv ====
// Purpose: Bus between one master port and the fabric
// Assumes: Both ends run on the same clock, which the testbench supplies
// Notes: No clocking block; the two ends are joined by the testbench

`timescale 1ns/10ps
`default_nettype none

interface bmb_if;
  import bmb_pkg::*;

  // Master to fabric
  logic [ADDR_W-1:0] address;
  logic [LANE_W-1:0] byte_lane_enable_n;
  logic read_n;
  logic write_n;
  logic [DATA_W-1:0] writedata;
  // Fabric to master
  logic [DATA_W-1:0] readdata;
  logic waitrequest;

  modport master (
    output address,
    output byte_lane_enable_n,
    output read_n,
    output write_n,
    output writedata,
    input readdata,
    input waitrequest
  );

  modport fabric (
    input address,
    input byte_lane_enable_n,
    input read_n,
    input write_n,
    input writedata,
    output readdata,
    output waitrequest
  );

endinterface : bmb_if

`default_nettype wire

// ==== rtl/bmb_fabric.sv ====
// Purpose: Fabric end of the basic transfer bus, facing one target
// Assumes: Target answers TGT_ACK with read data valid in the same cycle
// Notes: waitrequest and readdata follow the target in the same cycle

`timescale 1ns/10ps
`default_nettype none

module bmb_fabric
  import bmb_pkg::*;
#(
  parameter bit HAS_LANES = 1'b1
) (
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic RESET,
  // Bus
  bmb_if.fabric bus,
  // Target side
  output logic TGT_RD,
  output logic TGT_WR,
  output logic [ADDR_W-1:0] TGT_ADDR,
  output logic [LANE_W-1:0] TGT_LANES,
  output logic [DATA_W-1:0] TGT_WDATA,
  input wire logic TGT_ACK,
  input wire logic [DATA_W-1:0] TGT_RDATA,
  // Status
  output logic [CNT_W-1:0] WAIT_COUNT,
  output logic DONE,
  output logic PROTO_ERR
);

  logic active;
  logic stalled_r;
  logic [ADDR_W-1:0] addr_hold_r;
  logic [DATA_W-1:0] data_hold_r;
  logic [LANE_W-1:0] lane_hold_r;
  logic rd_hold_r;
  logic wr_hold_r;
  logic [LANE_W-1:0] lanes_n;
  logic [CNT_W-1:0] wait_cnt_r;
  logic done_r;
  logic err_r;

  // A master without lane enables gets every lane on every write
  assign lanes_n = HAS_LANES ? bus.byte_lane_enable_n : LANES_ALL_N;

  // Request towards the target, passed through in the same cycle
  assign active = ~bus.read_n | ~bus.write_n;
  assign TGT_RD = ~bus.read_n;
  assign TGT_WR = ~bus.write_n;
  assign TGT_ADDR = bus.address;
  assign TGT_LANES = ~lanes_n;
  assign TGT_WDATA = bus.writedata;

  // Stall until the target acknowledges; data rides with the acknowledge
  assign bus.waitrequest = active & ~TGT_ACK;
  assign bus.readdata = TGT_RDATA;

  // Wait states of the current transfer, reported when it completes
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      wait_cnt_r <= CNT_RST;
      WAIT_COUNT <= CNT_RST;
    end else if (active && bus.waitrequest) begin
      wait_cnt_r <= wait_cnt_r + 16'h0001;
    end else if (active) begin
      WAIT_COUNT <= wait_cnt_r;
      wait_cnt_r <= CNT_RST;
    end
  end

  // One-cycle completion pulse at the edge that ends a transfer
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      done_r <= 1'b0;
    end else begin
      done_r <= active & ~bus.waitrequest;
    end
  end
  assign DONE = done_r;

  // Snapshot of the master outputs while stalled
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      stalled_r <= 1'b0;
      addr_hold_r <= ADDR_RST;
      data_hold_r <= DATA_RST;
      lane_hold_r <= LANES_NONE_N;
      rd_hold_r <= STROBE_IDLE_N;
      wr_hold_r <= STROBE_IDLE_N;
    end else begin
      stalled_r <= bus.waitrequest;
      addr_hold_r <= bus.address;
      data_hold_r <= bus.writedata;
      lane_hold_r <= lanes_n;
      rd_hold_r <= bus.read_n;
      wr_hold_r <= bus.write_n;
    end
  end

  // Sticky flag for a master that moves while stalled or strobes both
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      err_r <= 1'b0;
    end else if (stalled_r && ((addr_hold_r != bus.address) || (rd_hold_r != bus.read_n)
                 || (wr_hold_r != bus.write_n) || (lane_hold_r != lanes_n)
                 || (!wr_hold_r && (data_hold_r != bus.writedata)))) begin
      err_r <= 1'b1;
    end else if (!bus.read_n && !bus.write_n) begin
      err_r <= 1'b1;
    end
  end
  assign PROTO_ERR = err_r;

endmodule : bmb_fabric

`default_nettype wire

// ==== rtl/bmb_master.sv ====
// Purpose: Master end of the basic transfer bus with a simple command port
// Assumes: Fabric keeps waitrequest and readdata per the transfer timing
// Notes: One transfer at a time; an idle cycle separates transfers
//
// Behaviour
// - Strobes and lane enables are active low
// - Read drives address, lanes, strobe at start
// - Zero-wait read: sample data, release, continue
// - Fabric raises waitrequest when data is late
// - N wait states give N plus one cycles
// - Hold all outputs while waitrequest high
// - Stalled read data valid when waitrequest drops
// - No timeout; stall as long as asked
// - Reads assert every byte lane
// - Write drives address, data, strobe, lanes
// - Stalled write holds address, data, strobe
// - Write ends at first low waitrequest
// - Lane enables are four bits, one per byte
// - Low enable bit selects its byte lane
// - Single byte uses its address and lane
// - Fabric enables all lanes without enables

`timescale 1ns/10ps
`default_nettype none

module bmb_master
  import bmb_pkg::*;
(
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic RESET,
  // Bus
  bmb_if.master bus,
  // Command port
  input wire logic CMD_VALID,
  input wire logic CMD_WRITE,
  input wire logic CMD_BYTE,
  input wire logic [ADDR_W-1:0] CMD_ADDR,
  input wire logic [LANE_W-1:0] CMD_LANES,
  input wire logic [DATA_W-1:0] CMD_WDATA,
  output logic CMD_READY,
  // Response port
  output logic RSP_VALID,
  output logic RSP_WRITE,
  output logic [DATA_W-1:0] RSP_RDATA,
  output logic [CNT_W-1:0] RSP_WAITS
);

  bmb_state_t state_r;
  bmb_state_t state_nxt;
  logic take;
  logic finish;
  logic [LANE_W-1:0] byte_lane_n;
  logic [LANE_W-1:0] wr_lanes_n;
  logic [DATA_W-1:0] wr_data;
  logic [ADDR_W-1:0] address_r;
  logic [LANE_W-1:0] lanes_n_r;
  logic read_n_r;
  logic write_n_r;
  logic [DATA_W-1:0] wdata_r;
  logic ready_r;
  logic rsp_valid_r;
  logic rsp_write_r;
  logic [DATA_W-1:0] rsp_rdata_r;
  logic [CNT_W-1:0] wait_cnt_r;
  logic [CNT_W-1:0] rsp_waits_r;

  // Command taken only while idle
  assign take = CMD_VALID & ready_r;

  // A transfer finishes at the first edge with waitrequest low
  assign finish = (state_r != BMB_IDLE) & ~bus.waitrequest;

  // Single byte: one low enable bit picked by the low address bits
  generate
    for (genvar i = 0; i < LANE_W; i++) begin : g_lane
      assign byte_lane_n[i] = (CMD_ADDR[1:0] != 2'(i));
      assign wr_data[8*i +: 8] = CMD_BYTE ? CMD_WDATA[7:0] : CMD_WDATA[8*i +: 8];
    end
  endgenerate

  // Lane selection applies to writes only; low bit enables a lane
  assign wr_lanes_n = CMD_BYTE ? byte_lane_n : ~CMD_LANES;

  // Next state of the transfer sequencer
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      BMB_IDLE: begin
        if (take) begin
          state_nxt = CMD_WRITE ? BMB_WRITE : BMB_READ;
        end
      end
      BMB_READ: begin
        if (!bus.waitrequest) begin
          state_nxt = BMB_IDLE;
        end
      end
      BMB_WRITE: begin
        if (!bus.waitrequest) begin
          state_nxt = BMB_IDLE;
        end
      end
      default: begin
        state_nxt = BMB_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      state_r <= BMB_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Bus outputs: driven at the starting edge, held while stalled
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      address_r <= ADDR_RST;
      lanes_n_r <= LANES_NONE_N;
      read_n_r <= STROBE_IDLE_N;
      write_n_r <= STROBE_IDLE_N;
      wdata_r <= DATA_RST;
    end else if (take) begin
      address_r <= CMD_ADDR;
      if (CMD_WRITE) begin
        write_n_r <= 1'b0;
        read_n_r <= STROBE_IDLE_N;
        lanes_n_r <= wr_lanes_n;
        wdata_r <= wr_data;
      end else begin
        read_n_r <= 1'b0;
        write_n_r <= STROBE_IDLE_N;
        lanes_n_r <= LANES_ALL_N;
      end
    end else if (finish) begin
      // Release everything at the completing edge
      address_r <= ADDR_RST;
      lanes_n_r <= LANES_NONE_N;
      read_n_r <= STROBE_IDLE_N;
      write_n_r <= STROBE_IDLE_N;
      wdata_r <= DATA_RST;
    end
    // Otherwise stalled or idle: nothing moves, with no limit on the stall
  end

  assign bus.address = address_r;
  assign bus.byte_lane_enable_n = lanes_n_r;
  assign bus.read_n = read_n_r;
  assign bus.write_n = write_n_r;
  assign bus.writedata = wdata_r;

  // Ready again in the cycle after a transfer completes
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      ready_r <= 1'b1;
    end else if (take) begin
      ready_r <= 1'b0;
    end else if (finish) begin
      ready_r <= 1'b1;
    end
  end
  assign CMD_READY = ready_r;

  // Wait-state counter for the transfer in flight
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      wait_cnt_r <= CNT_RST;
    end else if (take || finish) begin
      wait_cnt_r <= CNT_RST;
    end else if ((state_r != BMB_IDLE) && bus.waitrequest) begin
      wait_cnt_r <= wait_cnt_r + 16'h0001;
    end
  end

  // Response: read data captured at the completing edge
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      rsp_valid_r <= 1'b0;
      rsp_write_r <= 1'b0;
      rsp_rdata_r <= DATA_RST;
      rsp_waits_r <= CNT_RST;
    end else begin
      rsp_valid_r <= finish;
      if (finish) begin
        rsp_write_r <= (state_r == BMB_WRITE);
        rsp_waits_r <= wait_cnt_r;
        if (state_r == BMB_READ) begin
          rsp_rdata_r <= bus.readdata;
        end
      end
    end
  end

  assign RSP_VALID = rsp_valid_r;
  assign RSP_WRITE = rsp_write_r;
  assign RSP_RDATA = rsp_rdata_r;
  assign RSP_WAITS = rsp_waits_r;

endmodule : bmb_master

`default_nettype wire

// ==== sim/bmb_chk.sv ====
// Purpose: Protocol checker for the master-fabric link
// Assumes: One clock, synchronous active-high reset
// Notes: Sees only the interface signals

`timescale 1ns/10ps
`default_nettype none

module bmb_chk
  import bmb_pkg::*;
(
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic RESET,
  // Bus signals
  input wire logic [ADDR_W-1:0] address,
  input wire logic [LANE_W-1:0] byte_lane_enable_n,
  input wire logic read_n,
  input wire logic write_n,
  input wire logic [DATA_W-1:0] writedata,
  input wire logic [DATA_W-1:0] readdata,
  input wire logic waitrequest
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RESET);

  // Transfer phases
  sequence s_busy; !read_n || !write_n; endsequence
  sequence s_stall; s_busy ##0 waitrequest; endsequence
  sequence s_done; s_busy ##0 !waitrequest; endsequence

  // Protocol relations
  a_strobe_excl: assert property (read_n || write_n)
    else $error("both strobes low");
  a_read_lanes: assert property (!read_n |-> byte_lane_enable_n == LANES_ALL_N)
    else $error("read without all lanes");
  a_stall_hold: assert property (s_stall |=> $stable(address) &&
    $stable(byte_lane_enable_n) && $stable({read_n, write_n})) else $error("stall not held");
  a_write_hold: assert property (s_stall ##0 !write_n |=> $stable(writedata))
    else $error("write data moved");
  a_done_release: assert property (s_done |=> read_n && write_n && address == ADDR_RST)
    else $error("bus not released");
  a_wdata_release: assert property (s_done ##0 !write_n |=> writedata == DATA_RST)
    else $error("write data not released");
  a_idle_lanes: assert property (read_n && write_n |-> byte_lane_enable_n == LANES_NONE_N)
    else $error("lanes on while idle");
  a_idle_nowait: assert property (read_n && write_n |-> !waitrequest)
    else $error("stall while idle");
endmodule : bmb_chk

`default_nettype wire

// ==== sim/testbench.sv ====
// Purpose: Self-checking bench joining master and fabric ends
// Assumes: Bench plays the target behind the fabric
// Notes: Random waits and data from a fixed seed

`timescale 1ns/10ps
`default_nettype none

module testbench;
  import bmb_pkg::*;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic cmd_valid = 1'b0;
  logic cmd_write = 1'b0;
  logic cmd_byte = 1'b0;
  logic [3:0] cmd_lanes = 4'h0;
  logic [31:0] cmd_addr = '0;
  logic [31:0] cmd_wdata = '0;
  logic [31:0] tgt_rdata = '0;
  logic tgt_ack = 1'b0;
  logic cmd_ready, rsp_valid, rsp_write, tgt_rd, tgt_wr, done, proto_err;
  logic [3:0] tgt_lanes, tgt_lanes_nl;
  logic [31:0] rsp_rdata, tgt_addr, tgt_wdata, exp_rdata;
  logic [15:0] rsp_waits, wait_count;
  int num_errors = 0;
  int checked = 0;
  int seed = 32'h0000_f533;
  localparam logic [3:0] PATS [5] = '{LANES_ALL_N, LANES_LOW2_N, LANES_HIGH2_N,
    LANE0_ONLY_N, LANE2_ONLY_N};
  localparam int RWAITS [4] = '{0, 1, 2, 40};

  bmb_if bus ();
  bmb_master u_bmb_master (.SYS_CLK(sys_clk), .RESET(reset), .bus(bus.master),
    .CMD_VALID(cmd_valid), .CMD_WRITE(cmd_write), .CMD_BYTE(cmd_byte), .CMD_ADDR(cmd_addr),
    .CMD_LANES(cmd_lanes), .CMD_WDATA(cmd_wdata), .CMD_READY(cmd_ready),
    .RSP_VALID(rsp_valid), .RSP_WRITE(rsp_write), .RSP_RDATA(rsp_rdata), .RSP_WAITS(rsp_waits));
  bmb_fabric u_bmb_fabric (.SYS_CLK(sys_clk), .RESET(reset), .bus(bus.fabric),
    .TGT_RD(tgt_rd), .TGT_WR(tgt_wr), .TGT_ADDR(tgt_addr), .TGT_LANES(tgt_lanes),
    .TGT_WDATA(tgt_wdata), .TGT_ACK(tgt_ack), .TGT_RDATA(tgt_rdata),
    .WAIT_COUNT(wait_count), .DONE(done), .PROTO_ERR(proto_err));
  bmb_chk u_bmb_chk (.SYS_CLK(sys_clk), .RESET(reset), .address(bus.address),
    .byte_lane_enable_n(bus.byte_lane_enable_n), .read_n(bus.read_n), .write_n(bus.write_n),
    .writedata(bus.writedata), .readdata(bus.readdata), .waitrequest(bus.waitrequest));

  // Second fabric for a master without lane enables, fed from the same master outputs
  bmb_if bus_nl ();
  assign bus_nl.address = bus.address;
  assign bus_nl.byte_lane_enable_n = bus.byte_lane_enable_n;
  assign bus_nl.read_n = bus.read_n;
  assign bus_nl.write_n = bus.write_n;
  assign bus_nl.writedata = bus.writedata;
  bmb_fabric #(.HAS_LANES(1'b0)) u_bmb_fabric_nl (.SYS_CLK(sys_clk), .RESET(reset),
    .bus(bus_nl.fabric), .TGT_RD(), .TGT_WR(), .TGT_ADDR(), .TGT_LANES(tgt_lanes_nl),
    .TGT_WDATA(), .TGT_ACK(tgt_ack), .TGT_RDATA(tgt_rdata), .WAIT_COUNT(), .DONE(),
    .PROTO_ERR());

  // Clock
  always #20 sys_clk = ~sys_clk;

  // Compare and count
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // One transfer, target stalls n cycles
  task automatic xfer(input logic wr, input logic byt, input logic [31:0] a,
    input logic [31:0] d, input logic [3:0] ln, input int n);
    logic [3:0] el;
    el = !wr ? 4'hf : byt ? 4'h1 << a[1:0] : ln;
    @(posedge sys_clk);
    #1;
    check("cmd_ready", 32'(cmd_ready), 32'h1);
    cmd_valid = 1'b1;
    cmd_write = wr;
    cmd_byte = byt;
    cmd_addr = a;
    cmd_wdata = d;
    cmd_lanes = ln;
    @(posedge sys_clk);
    #1;
    cmd_valid = 1'b0;
    for (int i = 0; i <= n; i++) begin
      tgt_ack = (i == n);
      tgt_rdata = $random(seed);
      check("tgt_lanes", 32'(tgt_lanes), 32'(el));
      check("tgt_lanes_nl", 32'(tgt_lanes_nl), 32'h0000_000f);
      check("tgt_addr", tgt_addr, a);
      check("tgt_strobes", 32'({tgt_rd, tgt_wr}), 32'({!wr, wr}));
      if (wr) check("tgt_wdata", tgt_wdata, byt ? {4{d[7:0]}} : d);
      @(posedge sys_clk);
      #1;
    end
    if (!wr) exp_rdata = tgt_rdata;
    tgt_ack = 1'b0;
    check("bus_idle", 32'({bus.read_n, bus.write_n}), 32'h3);
    // Response and done pulse stand only in the cycle after the completing edge
    check("rsp", 32'({rsp_valid, rsp_write, done}), 32'({1'b1, wr, 1'b1}));
    check("rsp_rdata", rsp_rdata, exp_rdata);
    check("rsp_waits", 32'(rsp_waits), 32'(n));
    check("wait_count", 32'(wait_count), 32'(n));
  endtask : xfer

  // Verdict
  task automatic give_verdict();
    $display("Comparisons %0d, errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : give_verdict

  // Main sequence
  initial begin
    exp_rdata = '0;
    repeat (10) @(posedge sys_clk);
    #1;
    reset = 1'b0;
    foreach (PATS[i]) xfer(1'b1, 1'b0, $random(seed), $random(seed), ~PATS[i], i % 3);
    for (int i = 0; i < 4; i++) xfer(1'b1, 1'b1, 32'h0000_0100 + i, $random(seed), 4'h0, i);
    foreach (RWAITS[i]) xfer(1'b0, 1'b0, $random(seed), 32'h0, 4'h0, RWAITS[i]);
    repeat (30) xfer(1'($random(seed)), 1'($random(seed)), $random(seed), $random(seed),
      4'($random(seed)), $random(seed) & 7);
    check("proto_err", 32'(proto_err), 32'h0);
    give_verdict();
  end

  // Watchdog
  initial begin
    #80000;
    num_errors++;
    give_verdict();
  end
endmodule : testbench

`default_nettype wire
